// ### scmwc_top.sv
// serial channel 0 mode, clock source, wake-up and wait control
//
// The address-and-strobe port was chosen for this implementation.

module scmwc_top #(
	parameter int unsigned TIMER_DIV = 16
) (
	// clock and reset
	input wire logic CLK_I,
	input wire logic RESET_I,
	// register port
	input wire scmwc_pkg::scmwc_bus_s BUS_I,
	output logic [7:0] RDATA_O,
	// clock sources
	input wire logic TIMER_TWO_TICK_I,
	input wire logic PRESCALE_TICK_I,
	// bus pins
	input wire scmwc_pkg::scmwc_pins_in_s PINS_I,
	output scmwc_pkg::scmwc_pins_out_s PINS_O,
	// interrupt
	output logic IRQ_O
);
	import scmwc_pkg::*;

	// ==========================================
	// parameter check
	if (TIMER_DIV < 2 || TIMER_DIV > 256) begin : g_bad_div
		$error("TIMER_DIV must be 2 to 256");
	end

	localparam logic [7:0] DIV_LAST = 8'(TIMER_DIV - 1);

	// ==========================================
	// state
	logic [7:0] mode_reg;
	logic [7:0] timing_reg;
	logic [7:0] slave_addr;
	logic [7:0] shift_reg;
	logic [7:0] irq_status;
	logic [7:0] irq_mask;
	scmwc_state_e state;
	logic [3:0] bit_cnt;
	logic [7:0] div_cnt;
	logic sck_level;
	logic out_bit;
	logic sck_prev;
	logic sda_prev;
	logic start_seen;
	logic done_q;

	// ==========================================
	// decode
	logic enable;
	logic i2c_mode;
	logic lsb_first;
	logic master;
	logic sda_in;
	logic din;
	logic match;
	logic clock_pin_level;
	logic [3:0] bit_limit;
	logic div_hit;
	logic tick;
	logic rise_ev;
	logic fall_ev;
	logic start_ev;
	logic stop_ev;
	logic xfer_end;
	logic shift_wr;
	logic auto_arm;
	logic arm;
	logic wake_ok;
	logic set_xfer;
	logic status_rd;
	logic [7:0] events;
	logic [7:0] next_status;
	logic [7:0] next_mask;
	logic [7:0] next_rdata;
	scmwc_pins_out_s next_pins;

	always_comb begin
		enable = mode_reg[MODE_EN];
		i2c_mode = (mode_reg[4:3] == 2'b11);
		lsb_first = ~mode_reg[4] & mode_reg[2];
		master = mode_reg[1];
		sda_in = mode_reg[2] ? PINS_I.data_a : PINS_I.data_b;
		din = i2c_mode ? sda_in : PINS_I.data_a;
		match = enable & (((slave_addr ^ shift_reg) & (timing_reg[TIM_ADDRESS_MASK_SELECT] ? MASK_HI7 : MASK_ALL)) == 8'h00);
		clock_pin_level = enable & PINS_I.sck;
		bit_limit = (timing_reg[1:0] == WAIT_9) ? BITS_ACK : BITS_DATA;
		div_hit = TIMER_TWO_TICK_I & (div_cnt == DIV_LAST);
		if (mode_reg[0]) begin
			tick = PRESCALE_TICK_I;
		end else if (i2c_mode) begin
			tick = div_hit;
		end else begin
			tick = TIMER_TWO_TICK_I;
		end
		if (master) begin
			rise_ev = enable & (state == ST_XFER) & tick & ~sck_level;
			fall_ev = enable & (state == ST_XFER) & tick & sck_level;
		end else begin
			rise_ev = enable & (state == ST_XFER) & PINS_I.sck & ~sck_prev;
			fall_ev = enable & (state == ST_XFER) & ~PINS_I.sck & sck_prev;
		end
		start_ev = enable & i2c_mode & PINS_I.sck & sck_prev & sda_prev & ~sda_in;
		stop_ev = enable & i2c_mode & PINS_I.sck & sck_prev & ~sda_prev & sda_in;
		xfer_end = rise_ev & ((bit_cnt + 4'h1) == bit_limit);
		shift_wr = BUS_I.wr & (BUS_I.addr == ADDR_SHIFT) & enable & (state != ST_XFER);
		auto_arm = start_ev & ~master & (state != ST_XFER);
		arm = shift_wr | auto_arm;
		wake_ok = ~mode_reg[MODE_WUP] | (start_seen & match);
		set_xfer = timing_reg[TIM_SIC] ? stop_ev : (done_q & wake_ok);
		events = {5'h00, stop_ev, start_ev, set_xfer};
	end

	// ==========================================
	// operating mode register
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			mode_reg <= RST_MODE;
		end else if (BUS_I.wr && BUS_I.addr == ADDR_MODE) begin
			mode_reg <= {BUS_I.wdata[7], 1'b0, BUS_I.wdata[5:0]};
		end
	end

	// ==========================================
	// interrupt timing register
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			timing_reg <= RST_TIMING;
		end else if (BUS_I.wr && BUS_I.addr == ADDR_TIMING) begin
			timing_reg <= {2'b00, BUS_I.wdata[5:0]};
		end else if (timing_reg[TIM_WAIT_RELEASE]) begin
			timing_reg[TIM_WAIT_RELEASE] <= 1'b0;
		end
	end

	// ==========================================
	// slave address and mask registers
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			slave_addr <= RST_SLAVE;
		end else if (BUS_I.wr && BUS_I.addr == ADDR_SLAVE) begin
			slave_addr <= BUS_I.wdata;
		end
	end

	always_comb begin
		next_mask = irq_mask;
		if (BUS_I.wr && BUS_I.addr == ADDR_MASK) begin
			next_mask = BUS_I.wdata;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			irq_mask <= RST_MASK;
		end else begin
			irq_mask <= next_mask;
		end
	end

	// ==========================================
	// transfer state machine
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			state <= ST_IDLE;
		end else if (!enable) begin
			state <= ST_IDLE;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (arm) begin
						state <= ST_XFER;
					end
				end
				ST_XFER: begin
					if (xfer_end) begin
						state <= timing_reg[1] ? ST_WAIT : ST_IDLE;
					end
				end
				ST_WAIT: begin
					if (arm) begin
						state <= ST_XFER;
					end else if (timing_reg[TIM_WAIT_RELEASE]) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================
	// bit counter and timer divider
	always_ff @(posedge CLK_I) begin
		if (RESET_I || arm) begin
			bit_cnt <= 4'h0;
		end else if (rise_ev) begin
			bit_cnt <= bit_cnt + 4'h1;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I || state == ST_IDLE || !i2c_mode) begin
			div_cnt <= 8'h00;
		end else if (TIMER_TWO_TICK_I) begin
			div_cnt <= div_hit ? 8'h00 : div_cnt + 8'h01;
		end
	end

	// ==========================================
	// shift register
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			shift_reg <= RST_SHIFT;
		end else if (shift_wr) begin
			shift_reg <= BUS_I.wdata;
		end else if (auto_arm) begin
			shift_reg <= MASK_ALL;
		end else if (rise_ev && bit_cnt < BITS_DATA) begin
			shift_reg <= lsb_first ? {din, shift_reg[7:1]} : {shift_reg[6:0], din};
		end
	end

	// ==========================================
	// serial clock level and data bit
	always_ff @(posedge CLK_I) begin
		if (RESET_I || !enable) begin
			sck_level <= 1'b1;
		end else if (arm) begin
			sck_level <= 1'b1;
		end else if (state == ST_WAIT && (master ? tick : ~PINS_I.sck)) begin
			sck_level <= 1'b0;
		end else if (rise_ev || fall_ev) begin
			sck_level <= ~sck_level;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I || !enable) begin
			out_bit <= 1'b1;
		end else if (shift_wr) begin
			out_bit <= i2c_mode ? 1'b1 : (lsb_first ? BUS_I.wdata[0] : BUS_I.wdata[7]);
		end else if (auto_arm) begin
			out_bit <= 1'b1;
		end else if (fall_ev) begin
			out_bit <= (bit_cnt < BITS_DATA) ? (lsb_first ? shift_reg[0] : shift_reg[7]) : 1'b1;
		end
	end

	// ==========================================
	// line history, start tracking, end pulse
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			sck_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			sck_prev <= PINS_I.sck;
			sda_prev <= sda_in;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I || !enable) begin
			start_seen <= 1'b0;
		end else if (start_ev) begin
			start_seen <= 1'b1;
		end else if (done_q) begin
			start_seen <= 1'b0;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			done_q <= 1'b0;
		end else begin
			done_q <= xfer_end;
		end
	end

	// ==========================================
	// interrupt status and output
	always_comb begin
		status_rd = BUS_I.rd & (BUS_I.addr == ADDR_STATUS);
		next_status = (irq_status & (status_rd ? 8'h00 : 8'hFF)) | events;
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			irq_status <= RST_STATUS;
			IRQ_O <= 1'b0;
		end else begin
			irq_status <= next_status;
			IRQ_O <= |(next_status & next_mask);
		end
	end

	// ==========================================
	// pin drivers
	always_comb begin
		next_pins = '0;
		if (enable) begin
			if (i2c_mode) begin
				unique case (state)
					ST_XFER: next_pins.sck_oe = master & ~sck_level;
					ST_WAIT: next_pins.sck_oe = ~sck_level;
					default: next_pins.sck_oe = ~timing_reg[TIM_CLC];
				endcase
				if (mode_reg[2]) begin
					next_pins.a_oe = (state != ST_IDLE) & ~out_bit;
				end else begin
					next_pins.b_oe = (state != ST_IDLE) & ~out_bit;
				end
			end else begin
				next_pins.sck_o = sck_level;
				next_pins.sck_oe = master & (state == ST_XFER);
				next_pins.b_o = out_bit;
				next_pins.b_oe = 1'b1;
				next_pins.a_oe = 1'b0;
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			PINS_O <= '0;
		end else begin
			PINS_O <= next_pins;
		end
	end

	// ==========================================
	// read port
	always_comb begin
		next_rdata = 8'h00;
		if (BUS_I.rd) begin
			unique case (BUS_I.addr)
				ADDR_MODE: next_rdata = {mode_reg[7], match, mode_reg[5:0]};
				ADDR_TIMING: next_rdata = {1'b0, clock_pin_level, timing_reg[5:0]};
				ADDR_SLAVE: next_rdata = slave_addr;
				ADDR_SHIFT: next_rdata = shift_reg;
				ADDR_STATUS: next_rdata = irq_status;
				ADDR_MASK: next_rdata = irq_mask;
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			RDATA_O <= 8'h00;
		end else begin
			RDATA_O <= next_rdata;
		end
	end

endmodule : scmwc_top

// ### scmwc_pkg.sv
// constants and carrier types for the serial channel 0 mode and wait control
package scmwc_pkg;

	// ==========================================
	// register addresses
	localparam logic [15:0] ADDR_MODE = 16'hFF60;
	localparam logic [15:0] ADDR_TIMING = 16'hFF63;
	localparam logic [15:0] ADDR_SLAVE = 16'hFF64;
	localparam logic [15:0] ADDR_SHIFT = 16'hFF65;
	localparam logic [15:0] ADDR_STATUS = 16'hFF66;
	localparam logic [15:0] ADDR_MASK = 16'hFF67;

	// ==========================================
	// reset values
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_TIMING = 8'h00;
	localparam logic [7:0] RST_SLAVE = 8'h00;
	localparam logic [7:0] RST_SHIFT = 8'h00;
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h00;

	// ==========================================
	// field positions
	localparam int MODE_EN = 7;
	localparam int MODE_WUP = 5;
	localparam int TIM_SIC = 5;
	localparam int TIM_ADDRESS_MASK_SELECT = 4;
	localparam int TIM_CLC = 3;
	localparam int TIM_WAIT_RELEASE = 2;
	localparam int STAT_XFER = 0;
	localparam int STAT_START = 1;
	localparam int STAT_STOP = 2;

	// ==========================================
	// field codes and counts
	localparam logic [1:0] WAIT_9 = 2'b11;
	localparam logic [3:0] BITS_DATA = 4'h8;
	localparam logic [3:0] BITS_ACK = 4'h9;
	localparam logic [7:0] MASK_ALL = 8'hFF;
	localparam logic [7:0] MASK_HI7 = 8'hFE;

	// ==========================================
	// types
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_XFER = 2'b01,
		ST_WAIT = 2'b10
	} scmwc_state_e;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} scmwc_bus_s;

	typedef struct packed {
		logic sck;
		logic data_a;
		logic data_b;
	} scmwc_pins_in_s;

	typedef struct packed {
		logic sck_o;
		logic sck_oe;
		logic a_o;
		logic a_oe;
		logic b_o;
		logic b_oe;
	} scmwc_pins_out_s;

endpackage : scmwc_pkg

// ### scmwc_peer.sv
// far-side bus peer: pull-ups, wired line levels and clock stretching
module scmwc_peer (
	// pins from the device
	input wire scmwc_pkg::scmwc_pins_out_s pins_o,
	// peer holds the clock line low
	input wire logic stretch_i,
	// peer pulls data line a low
	input wire logic sda_low_i,
	// resolved line levels
	output scmwc_pkg::scmwc_pins_in_s pins_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// released lines float high
	assign pins_i = '{(pins_o.sck_oe ? pins_o.sck_o : 1'b1) & ~stretch_i,
		(pins_o.a_oe ? pins_o.a_o : 1'b1) & ~sda_low_i,
		pins_o.b_oe ? pins_o.b_o : 1'b1};
endmodule : scmwc_peer

// ### scmwc_props.sv
// assertions on the ports of the mode and wait control
module scmwc_props (
	// clock and reset
	input wire logic CLK_I,
	input wire logic RESET_I,
	// register port
	input wire scmwc_pkg::scmwc_bus_s BUS_I,
	input wire logic [7:0] RDATA_O,
	// clock sources
	input wire logic TIMER_TWO_TICK_I,
	input wire logic PRESCALE_TICK_I,
	// pins and interrupt
	input wire scmwc_pkg::scmwc_pins_in_s PINS_I,
	input wire scmwc_pkg::scmwc_pins_out_s PINS_O,
	input wire logic IRQ_O
);
	timeunit 1ns;
	timeprecision 1ps;
	import scmwc_pkg::*;
	logic [7:0] mode;
	logic [7:0] mask;
	logic rd_m;
	logic rd_t;
	logic i2c;
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (RESET_I);
	assign rd_m = BUS_I.rd && BUS_I.addr == ADDR_MODE;
	assign rd_t = BUS_I.rd && BUS_I.addr == ADDR_TIMING;
	assign i2c = mode[7] && mode[4:3] == 2'b11;
	// ==========================================
	// shadow of written mode and mask
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			mode <= RST_MODE;
			mask <= RST_MASK;
		end else if (BUS_I.wr && BUS_I.addr == ADDR_MODE) begin
			mode <= BUS_I.wdata;
		end else if (BUS_I.wr && BUS_I.addr == ADDR_MASK) begin
			mask <= BUS_I.wdata;
		end
	end
	// ==========================================
	// assertions
	rd_slot_a: assert property (!BUS_I.rd |=> RDATA_O == 8'h00)
		else $error("read data outside slot");
	bit_seven_a: assert property (rd_t |=> !RDATA_O[7])
		else $error("timing bit 7 set");
	unmapped_rd_a: assert property (BUS_I.rd && BUS_I.addr == 16'hFF61 |=> RDATA_O == 8'h00)
		else $error("unmapped read not zero");
	match_off_a: assert property (rd_m && !mode[7] |=> !RDATA_O[6])
		else $error("match flag while disabled");
	level_off_a: assert property (rd_t && !mode[7] |=> !RDATA_O[6])
		else $error("pin level while disabled");
	halt_pins_a: assert property (!mode[7] [*3] |-> !(PINS_O.sck_oe || PINS_O.a_oe || PINS_O.b_oe))
		else $error("pin driven while disabled");
	open_drain_a: assert property (i2c [*3] |-> !(PINS_O.sck_o || PINS_O.a_o || PINS_O.b_o))
		else $error("open drain pin driven high");
	pin_a_free_a: assert property ((mode[4:2] != 3'b111) [*3] |-> !PINS_O.a_oe)
		else $error("pin a driven");
	irq_mask_a: assert property (IRQ_O |-> mask != 8'h00)
		else $error("interrupt while all masked");
	wait_release_clear_a: assert property (BUS_I.wr && BUS_I.addr == ADDR_TIMING && BUS_I.wdata[2] ##2 rd_t |=> !RDATA_O[2])
		else $error("wait release stuck");
	cover property (IRQ_O);
	cover property (rd_m ##1 RDATA_O[6]);
	cover property (i2c ##1 !PINS_O.sck_oe);
endmodule : scmwc_props
bind scmwc_top scmwc_props props_u (.CLK_I(CLK_I), .RESET_I(RESET_I), .BUS_I(BUS_I), .RDATA_O(RDATA_O),
	.TIMER_TWO_TICK_I(TIMER_TWO_TICK_I), .PRESCALE_TICK_I(PRESCALE_TICK_I), .PINS_I(PINS_I),
	.PINS_O(PINS_O), .IRQ_O(IRQ_O));

// ### scmwc_top_test.sv
// self-checking bench for the mode and wait control
module scmwc_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import scmwc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	scmwc_bus_s bus = '0;
	logic t2 = 1'b0;
	logic pre = 1'b0;
	logic hold = 1'b0;
	logic drop = 1'b0;
	logic [7:0] rdata;
	logic irq;
	scmwc_pins_in_s pin_in;
	scmwc_pins_out_s pin_out;
	logic [31:0] seed = 32'h012ADF5D;
	int fail_count = 0;
	int n_compared = 0;
	bit [7:0] m_mode, m_tim, m_slave, m_shift, m_stat, m_mask;
	bit m_pin;
	scmwc_top dut_u (.CLK_I(clk), .RESET_I(rst), .BUS_I(bus), .RDATA_O(rdata), .TIMER_TWO_TICK_I(t2),
		.PRESCALE_TICK_I(pre), .PINS_I(pin_in), .PINS_O(pin_out), .IRQ_O(irq));
	scmwc_peer peer_u (.pins_o(pin_out), .stretch_i(hold), .sda_low_i(drop), .pins_i(pin_in));
	initial begin
		forever #2 clk = ~clk;
	end
	// ==========================================
	// random clock ticks
	function automatic logic [31:0] lfsr_next(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	always @(posedge clk) begin
		seed <= lfsr_next(seed);
		pre <= seed[0];
		t2 <= seed[3];
	end
	// ==========================================
	// model and bus tasks
	function automatic bit [7:0] model_rd(bit [15:0] a);
		bit [7:0] cmp;
		cmp = m_tim[4] ? 8'hFE : 8'hFF;
		case (a)
			ADDR_MODE: return {m_mode[7], m_mode[7] && ((m_slave ^ m_shift) & cmp) == 8'h00, m_mode[5:0]};
			ADDR_TIMING: return {1'b0, m_mode[7] && m_pin, m_tim[5:3], 1'b0, m_tim[1:0]};
			ADDR_STATUS: return m_stat;
			default: return 8'h00;
		endcase
	endfunction : model_rd
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude
	task automatic check(logic [7:0] got, bit [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic wr(bit [15:0] a, bit [7:0] d);
		@(posedge clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus <= '0;
		case (a)
			ADDR_MODE: m_mode = d;
			ADDR_TIMING: m_tim = d & 8'h3B;
			ADDR_SLAVE: m_slave = d;
			ADDR_MASK: m_mask = d;
			default: ;
		endcase
	endtask : wr
	task automatic rd(bit [15:0] a);
		@(posedge clk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus <= '0;
		#1;
		check(rdata, model_rd(a));
		if (a == ADDR_STATUS) m_stat = 8'h00;
	endtask : rd
	task automatic setmode(bit [7:0] m);
		wr(ADDR_MODE, m_mode & 8'h7F);
		wr(ADDR_MODE, m & 8'h7F);
		wr(ADDR_MODE, m);
	endtask : setmode
	task automatic xfer(bit [7:0] d, bit lsb, int nclk);
		logic q[$];
		logic last;
		int n;
		last = 1'b1;
		n = 0;
		wr(ADDR_SHIFT, d);
		while (q.size() < nclk && n < 4000) begin
			@(posedge clk);
			#1;
			if (pin_in.sck && !last) q.push_back(m_mode[3] ? pin_in.data_a : pin_in.data_b);
			last = pin_in.sck;
			n++;
		end
		if (q.size() < nclk) begin
			fail_count++;
			conclude();
		end
		for (int i = 0; i < 8; i++) check({7'h00, q[i]}, {7'h00, lsb ? d[i] : d[7 - i]});
		if (nclk == 9) check({7'h00, q[8]}, 8'h01);
		repeat (6) @(posedge clk);
		#1;
		m_stat = 8'h01;
		m_shift = m_mode[3] ? d : 8'hFF;
		check({7'h00, irq}, {7'h00, m_mask[0]});
		if (!m_tim[1]) check({7'h00, pin_out.sck_oe}, 8'h00);
	endtask : xfer
	task automatic wait_low();
		int n;
		n = 0;
		while (pin_in.sck && n < 4000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (pin_in.sck) begin
			fail_count++;
			conclude();
		end
		repeat (40) @(posedge clk);
		#1;
		check({6'h00, pin_out.sck_oe, pin_in.sck}, 8'h02);
	endtask : wait_low
	// ==========================================
	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(ADDR_MODE);
		rd(ADDR_TIMING);
		rd(16'hFF61);
		wr(ADDR_TIMING, 8'hF7);
		rd(ADDR_TIMING);
		wr(ADDR_TIMING, 8'h00);
		wr(ADDR_SLAVE, 8'h01);
		setmode(8'h83);
		rd(ADDR_MODE);
		wr(ADDR_TIMING, 8'h10);
		rd(ADDR_MODE);
		wr(ADDR_MASK, 8'h01);
		xfer(seed[15:8], 1'b0, 8);
		rd(ADDR_STATUS);
		setmode(8'h87);
		wr(ADDR_MASK, 8'h00);
		xfer(seed[23:16], 1'b1, 8);
		wr(ADDR_MASK, 8'h01);
		#1;
		check({7'h00, irq}, 8'h01);
		rd(ADDR_STATUS);
		check({7'h00, irq}, 8'h00);
		setmode(8'h9F);
		wr(ADDR_TIMING, 8'h00);
		repeat (3) @(posedge clk);
		#1;
		check({6'h00, pin_out.sck_oe, pin_out.sck_o}, 8'h02);
		wr(ADDR_TIMING, 8'h08);
		m_pin = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		check({7'h00, pin_out.sck_oe}, 8'h00);
		rd(ADDR_TIMING);
		hold <= 1'b1;
		m_pin = 1'b0;
		repeat (4) @(posedge clk);
		rd(ADDR_TIMING);
		hold <= 1'b0;
		m_pin = 1'b1;
		wr(ADDR_TIMING, 8'h0C);
		rd(ADDR_TIMING);
		wr(ADDR_TIMING, 8'h28);
		drop <= 1'b1;
		repeat (3) @(posedge clk);
		drop <= 1'b0;
		repeat (3) @(posedge clk);
		m_stat = 8'h07;
		rd(ADDR_STATUS);
		setmode(8'h9E);
		wr(ADDR_TIMING, 8'h0B);
		xfer(seed[31:24], 1'b0, 9);
		wait_low();
		wr(ADDR_TIMING, 8'h0F);
		repeat (3) @(posedge clk);
		#1;
		check({7'h00, pin_out.sck_oe}, 8'h00);
		rd(ADDR_STATUS);
		conclude();
	end
endmodule : scmwc_top_test
